/* File: verilog/sca_top.sv */
/*
  Control logic of the clocking subsystem: aperture delay ramp, SYSREF windowing and
  automatic SYSREF alignment, with an AXI4-Lite register slave.
  Assumes the analog delay line returns SYSREF sampled at the 24 candidate phases on
  PHASE_SAMPLE_I and a phase detector on CAL_EDGE_PAST_I; both are asynchronous.
*/
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module sca_top (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic SYSREF_I,
  input wire logic [23:0] PHASE_SAMPLE_I,
  input wire logic CAL_EDGE_PAST_I,
  output sca_pkg::sca_dly_s DLY_O,
  output logic WINDOW_STEP_FINE_O,
  output logic [3:0] CAPTURE_POSITION_SELECT_O,
  output logic SYSREF_CAPTURED_O,
  output logic ALIGN_CAL_BUSY_O,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ==========================================================
  // Helpers.
  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt,
                                             input logic [7:0] step);
    logic [7:0] diff;
    diff = (tgt > cur) ? tgt - cur : cur - tgt;
    if (diff <= step) step_toward = tgt;
    else if (tgt > cur) step_toward = cur + step;
    else step_toward = cur - step;
  endfunction

  // A phase whose sample differs from a neighbour sits on the SYSREF edge.
  function automatic logic [23:0] win_flags(input logic [23:0] s);
    logic [23:0] f;
    f = '0;
    for (int i = 1; i < sca_pkg::MAP_W - 1; i++) begin
      f[i] = (s[i] ^ s[i+1]) | (s[i] ^ s[i-1]);
    end
    win_flags = f | sca_pkg::MAP_ENDS;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) m[b*8 +: 8] = nw[b*8 +: 8];
    end
    merge = m;
  endfunction

  // ==========================================================
  // Input synchronisers.
  logic [25:0] sync1, sync2;
  logic sys_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      sync1 <= '0;
      sync2 <= '0;
      sys_q <= 1'b0;
    end else begin
      sync1 <= {CAL_EDGE_PAST_I, SYSREF_I, PHASE_SAMPLE_I};
      sync2 <= sync1;
      sys_q <= sync2[24];
    end
  end
  logic [23:0] samp;
  logic det_s, sys_rise;
  assign samp = sync2[23:0];
  assign det_s = sync2[25];
  assign sys_rise = sync2[24] & ~sys_q;

  // ==========================================================
  // Register bus and software fields.
  logic aw_q, w_q, bvalid, rvalid;
  logic [11:0] awaddr;
  logic [31:0] wdata, rdata, dly_ctrl, cal_cfg;
  logic [3:0] wstrb, sel;
  logic [1:0] bresp, rresp;
  logic zoom, cal_en;
  logic next_aw_q, next_w_q, next_bvalid, next_rvalid, next_zoom, next_cal_en;
  logic [11:0] next_awaddr;
  logic [31:0] next_wdata, next_rdata, next_dly_ctrl, next_cal_cfg, rd_val;
  logic [3:0] next_wstrb, next_sel;
  logic [1:0] next_bresp, next_rresp;
  logic commit, coarse_wr, zoom_chg, cal_start, rd_ok;
  logic [7:0] wr_idx, rd_idx;
  logic [23:0] map_val, acc;
  logic [1:0] edges;
  logic done, busy;
  logic [7:0] res_c;
  logic res_i;
  sca_pkg::sca_dly_s dly;

  assign S_AXI_AWREADY = ~aw_q & ~bvalid;
  assign S_AXI_WREADY = ~w_q & ~bvalid;
  assign S_AXI_ARREADY = ~rvalid;
  assign commit = aw_q & w_q & ~bvalid;
  assign wr_idx = awaddr[9:2];
  assign rd_idx = S_AXI_ARADDR[9:2];

  always_comb begin
    next_aw_q = aw_q;
    next_w_q = w_q;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_dly_ctrl = dly_ctrl;
    next_sel = sel;
    next_zoom = zoom;
    next_cal_cfg = cal_cfg;
    next_cal_en = cal_en;
    coarse_wr = 1'b0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_q = 1'b1;
      next_awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_q = 1'b1;
      next_wdata = S_AXI_WDATA;
      next_wstrb = S_AXI_WSTRB;
    end
    if (bvalid && S_AXI_BREADY) next_bvalid = 1'b0;
    if (commit) begin
      next_aw_q = 1'b0;
      next_w_q = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = sca_pkg::RESP_OKAY;
      if (awaddr[11:10] != 2'h0) begin
        next_bresp = sca_pkg::RESP_SLVERR;
      end else begin
        case (wr_idx)
          sca_pkg::IDX_DLY_CTRL: begin
            next_dly_ctrl = merge(dly_ctrl, wdata, wstrb) & 32'h0007FFFF;
            coarse_wr = wstrb[0];
          end
          sca_pkg::IDX_CAP_CTRL: begin
            if (wstrb[0]) begin
              next_sel = wdata[sca_pkg::SEL_W-1:0];
              next_zoom = wdata[sca_pkg::CC_ZOOM_BIT];
            end
          end
          sca_pkg::IDX_CAL_CFG: next_cal_cfg = merge(cal_cfg, wdata, wstrb);
          sca_pkg::IDX_CAL_EN: if (wstrb[0]) next_cal_en = wdata[0];
          sca_pkg::IDX_MAP_LOW, sca_pkg::IDX_MAP_MID, sca_pkg::IDX_MAP_HIGH,
          sca_pkg::IDX_CAL_STAT, sca_pkg::IDX_DLY_APPLIED: next_bresp = sca_pkg::RESP_OKAY;
          default: next_bresp = sca_pkg::RESP_SLVERR;
        endcase
      end
    end
  end
  assign zoom_chg = next_zoom != zoom;
  assign cal_start = next_cal_en & ~cal_en;

  assign map_val = acc | sca_pkg::MAP_ENDS;
  always_comb begin
    rd_val = 32'h0;
    rd_ok = S_AXI_ARADDR[11:10] == 2'h0;
    case (rd_idx)
      sca_pkg::IDX_MAP_LOW: rd_val = {24'h0, map_val[7:0]};
      sca_pkg::IDX_MAP_MID: rd_val = {24'h0, map_val[15:8]};
      sca_pkg::IDX_MAP_HIGH: rd_val = {24'h0, map_val[23:16]};
      sca_pkg::IDX_DLY_CTRL: rd_val = dly_ctrl;
      sca_pkg::IDX_CAP_CTRL: rd_val = {27'h0, zoom, sel};
      sca_pkg::IDX_CAL_CFG: rd_val = cal_cfg;
      sca_pkg::IDX_CAL_EN: rd_val = {31'h0, cal_en};
      sca_pkg::IDX_CAL_STAT: rd_val = {15'h0, res_i, res_c, 5'h0, busy,
                                      edges == sca_pkg::WIN_VALID_EDGES, done};
      sca_pkg::IDX_DLY_APPLIED: rd_val = {15'h0, dly};
      default: rd_ok = 1'b0;
    endcase
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && S_AXI_RREADY) next_rvalid = 1'b0;
    if (S_AXI_ARVALID && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = rd_ok ? rd_val : 32'h0;
      next_rresp = rd_ok ? sca_pkg::RESP_OKAY : sca_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr <= '0;
      wdata <= '0;
      wstrb <= '0;
      bvalid <= 1'b0;
      bresp <= sca_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= sca_pkg::RESP_OKAY;
      dly_ctrl <= '0;
      sel <= '0;
      zoom <= 1'b0;
      cal_cfg <= sca_pkg::CAL_CFG_RESET;
      cal_en <= 1'b0;
    end else begin
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      dly_ctrl <= next_dly_ctrl;
      sel <= next_sel;
      zoom <= next_zoom;
      cal_cfg <= next_cal_cfg;
      cal_en <= next_cal_en;
    end
  end
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;

  // ==========================================================
  // Ramp, windowing and alignment search.
  logic [7:0] tgt, applied, ramp_cnt, cal_c, best_c;
  logic [7:0] next_applied, next_ramp_cnt, next_cal_c, next_best_c, next_res_c;
  logic [23:0] next_acc;
  logic [1:0] next_edges, step_e, next_step_e;
  logic ramp_en, ramp_fast, cal_i, best_i, found, capt;
  logic next_cal_i, next_best_i, next_found, next_done, next_res_i, next_capt;
  logic cand, pass_end, enter_done;
  sca_pkg::sca_cal_e state, next_state;
  sca_pkg::sca_dly_s next_dly;

  assign tgt = dly_ctrl[sca_pkg::DC_COARSE_LSB +: 8];
  assign ramp_en = dly_ctrl[sca_pkg::DC_RAMP_EN_BIT];
  assign ramp_fast = dly_ctrl[sca_pkg::DC_RAMP_FAST_BIT];
  assign busy = (state == sca_pkg::CAL_WAIT) | (state == sca_pkg::CAL_CHECK);
  assign cand = det_s & (~found | (cal_c < best_c));
  assign pass_end = det_s | (cal_c == sca_pkg::COARSE_MAX);

  always_comb begin
    next_ramp_cnt = coarse_wr ? 8'h00 : ramp_cnt + 8'h01;
    next_applied = applied;
    if (!ramp_en) next_applied = tgt;
    else if (ramp_cnt == sca_pkg::RAMP_LAST)
      next_applied = step_toward(applied, tgt, ramp_fast ? sca_pkg::STEP_FAST : sca_pkg::STEP_SLOW);
    next_edges = zoom_chg ? 2'h0 : edges;
    next_acc = zoom_chg ? 24'h0 : acc;
    if (sys_rise) begin
      next_acc = next_acc | win_flags(samp);
      if (next_edges != sca_pkg::WIN_VALID_EDGES) next_edges = next_edges + 2'h1;
    end
    next_capt = samp[sel];
    next_state = state;
    next_cal_c = cal_c;
    next_cal_i = cal_i;
    next_step_e = step_e;
    next_found = found;
    next_best_c = best_c;
    next_best_i = best_i;
    next_res_c = res_c;
    next_res_i = res_i;
    enter_done = 1'b0;
    case (state)
      sca_pkg::CAL_IDLE: begin
        if (cal_start) begin
          next_state = sca_pkg::CAL_WAIT;
          next_cal_c = 8'h00;
          next_cal_i = 1'b0;
          next_step_e = 2'h0;
          next_found = 1'b0;
        end
      end
      sca_pkg::CAL_WAIT: begin
        if (sys_rise) begin
          next_step_e = step_e + 2'h1;
          if (step_e == sca_pkg::CAL_EDGES_LAST) begin
            next_state = sca_pkg::CAL_CHECK;
            next_step_e = 2'h0;
          end
        end
      end
      sca_pkg::CAL_CHECK: begin
        if (cand) begin
          next_found = 1'b1;
          next_best_c = cal_c;
          next_best_i = cal_i;
        end
        next_state = sca_pkg::CAL_WAIT;
        if (!pass_end) next_cal_c = cal_c + 8'h01;
        else if (!cal_i) begin
          next_cal_i = 1'b1;
          next_cal_c = 8'h00;
        end else begin
          next_state = sca_pkg::CAL_DONE;
          enter_done = 1'b1;
          next_res_c = next_found ? next_best_c : sca_pkg::COARSE_MAX;
          next_res_i = next_found & next_best_i;
        end
      end
      sca_pkg::CAL_DONE: next_state = sca_pkg::CAL_DONE;
      default: next_state = sca_pkg::CAL_IDLE;
    endcase
    if (!next_cal_en) next_state = sca_pkg::CAL_IDLE;
    // Completion wins over a clear in the same cycle.
    next_done = enter_done | (done & next_cal_en);
    next_dly.fine = dly_ctrl[sca_pkg::DC_FINE_LSB +: 8];
    next_dly.coarse = applied;
    next_dly.inv = dly_ctrl[sca_pkg::DC_INV_BIT];
    if (busy) begin
      next_dly.coarse = cal_c;
      next_dly.inv = cal_i;
    end else if (cal_en && done) begin
      next_dly.coarse = res_c;
      next_dly.inv = res_i;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      applied <= '0;
      ramp_cnt <= '0;
      acc <= '0;
      edges <= '0;
      capt <= 1'b0;
      state <= sca_pkg::CAL_IDLE;
      cal_c <= '0;
      cal_i <= 1'b0;
      step_e <= '0;
      found <= 1'b0;
      best_c <= '0;
      best_i <= 1'b0;
      res_c <= '0;
      res_i <= 1'b0;
      done <= 1'b0;
      dly <= '0;
    end else begin
      applied <= next_applied;
      ramp_cnt <= next_ramp_cnt;
      acc <= next_acc;
      edges <= next_edges;
      capt <= next_capt;
      state <= next_state;
      cal_c <= next_cal_c;
      cal_i <= next_cal_i;
      step_e <= next_step_e;
      found <= next_found;
      best_c <= next_best_c;
      best_i <= next_best_i;
      res_c <= next_res_c;
      res_i <= next_res_i;
      done <= next_done;
      dly <= next_dly;
    end
  end
  assign DLY_O = dly;
  assign WINDOW_STEP_FINE_O = zoom;
  assign CAPTURE_POSITION_SELECT_O = sel;
  assign SYSREF_CAPTURED_O = capt;
  assign ALIGN_CAL_BUSY_O = busy;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic rd_low;
  assign rd_low = S_AXI_ARVALID & ~rvalid & (S_AXI_ARADDR == {2'h0, sca_pkg::IDX_MAP_LOW, 2'h0});
  sequence s_done_set;
    (state == sca_pkg::CAL_CHECK) ##1 (state == sca_pkg::CAL_DONE);
  endsequence
  property p_ramp_step;
    ramp_en && $past(ramp_en) && $changed(applied) |-> $past(ramp_cnt) == sca_pkg::RAMP_LAST;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp moved off period");
  property p_ramp_rate;
    ramp_en && $past(ramp_en) && !ramp_fast && $past(!ramp_fast) && $changed(applied)
      |-> (applied - $past(applied) == 8'h01) || ($past(applied) - applied == 8'h01);
  endproperty
  a_ramp_rate: assert property (p_ramp_rate) else $error("slow ramp step wrong");
  property p_retarget;
    ramp_en && coarse_wr |=> ramp_cnt == 8'h00 ##1 ramp_cnt == 8'h01;
  endproperty
  a_retarget: assert property (p_retarget) else $error("coarse write did not restart");
  property p_valid;
    $rose(edges == sca_pkg::WIN_VALID_EDGES) |-> $past(sys_rise);
  endproperty
  a_valid: assert property (p_valid) else $error("window valid without edge");
  property p_ends;
    rd_low |=> rvalid && rdata[0];
  endproperty
  a_ends: assert property (p_ends) else $error("map end bit not one");
  property p_capt;
    ##1 SYSREF_CAPTURED_O == $past(samp[sel]);
  endproperty
  a_capt: assert property (p_capt) else $error("capture phase wrong");
  property p_done;
    $rose(done) |-> $past(state == sca_pkg::CAL_CHECK && pass_end && cal_i);
  endproperty
  a_done: assert property (p_done) else $error("done without search");
  property p_hold;
    s_done_set ##0 cal_en |=> ##[0:1] (dly.coarse == res_c && dly.inv == res_i);
  endproperty
  a_hold: assert property (p_hold) else $error("calibrated delay not applied");
endmodule

/* File: verilog/sca_pkg.sv */
/*
  Constants, register map and carrier types of the SYSREF capture and alignment block.
  Assumes a single 125 MHz core clock and an AXI4-Lite register bus with 32-bit data.
*/
package sca_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_MAP_LOW = 8'h2C;
  localparam logic [7:0] IDX_MAP_MID = 8'h2D;
  localparam logic [7:0] IDX_MAP_HIGH = 8'h2E;
  localparam logic [7:0] IDX_DLY_CTRL = 8'h30;
  localparam logic [7:0] IDX_CAP_CTRL = 8'h31;
  localparam logic [7:0] IDX_CAL_CFG = 8'h32;
  localparam logic [7:0] IDX_CAL_EN = 8'h33;
  localparam logic [7:0] IDX_CAL_STAT = 8'h34;
  localparam logic [7:0] IDX_DLY_APPLIED = 8'h35;
  // ==========================================================
  // Field positions.
  localparam int DC_COARSE_LSB = 0;
  localparam int DC_FINE_LSB = 8;
  localparam int DC_INV_BIT = 16;
  localparam int DC_RAMP_EN_BIT = 17;
  localparam int DC_RAMP_FAST_BIT = 18;
  localparam int CC_ZOOM_BIT = 4;
  localparam int CS_DONE_BIT = 0;
  localparam int CS_VALID_BIT = 1;
  localparam int CS_BUSY_BIT = 2;
  localparam int CS_COARSE_LSB = 8;
  localparam int CS_INV_BIT = 16;
  // ==========================================================
  // Sizes, reset values and counts.
  localparam int MAP_W = 24;
  localparam int SEL_W = 4;
  localparam logic [23:0] MAP_ENDS = 24'h800001;
  localparam logic [7:0] RAMP_LAST = 8'hFF;
  localparam logic [7:0] STEP_SLOW = 8'h01;
  localparam logic [7:0] STEP_FAST = 8'h04;
  localparam logic [7:0] COARSE_MAX = 8'hFF;
  localparam logic [1:0] WIN_VALID_EDGES = 2'h3;
  localparam logic [1:0] CAL_EDGES_LAST = 2'h1;
  localparam logic [31:0] CAL_CFG_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  typedef struct packed {
    logic inv;
    logic [7:0] coarse;
    logic [7:0] fine;
  } sca_dly_s;
  typedef enum logic [3:0] {
    CAL_IDLE = 4'h1,
    CAL_WAIT = 4'h2,
    CAL_CHECK = 4'h4,
    CAL_DONE = 4'h8
  } sca_cal_e;
endpackage

/* File: bench/sca_clkgen_model.sv */
/*
  Behavioural model of the external clock generator: periodic SYSREF, the phase
  samples of the analog delay line and the alignment phase detector.
  Assumes the bench drives run_i and the detector thresholds off the sampling edge.
*/
`timescale 1ns/1ps
module sca_clkgen_model #(
  parameter int PERIOD = 16,
  parameter logic [23:0] PATTERN = 24'h0000F0
) (
  input wire logic clk_i,
  input wire logic run_i,
  input sca_pkg::sca_dly_s dly_i,
  input wire logic [7:0] thr_norm_i,
  input wire logic [7:0] thr_inv_i,
  output logic sysref_o,
  output logic [23:0] phase_sample_o,
  output logic edge_past_o
);
  // ==========================================================
  // Reference generation
  int cnt;
  always_ff @(posedge clk_i) begin
    cnt <= run_i ? (cnt + 1) % PERIOD : 0;
  end
  assign sysref_o = run_i && (cnt < PERIOD / 2);
  // The skew is fixed, so every rise sees the same sampled pattern.
  assign phase_sample_o = PATTERN;
  // ==========================================================
  // Phase detector
  // Delay moves detector.
  always_comb begin
    edge_past_o = dly_i.inv ? (dly_i.coarse >= thr_inv_i) : (dly_i.coarse >= thr_norm_i);
  end
endmodule

/* File: bench/tb_sca_top.sv */
/*
  Self-checking bench of the SYSREF capture and alignment block over AXI4-Lite.
  Assumes the clock generator model on the far side and a 125 MHz core clock.
*/
`timescale 1ns/1ps
module tb_sca_top;
  localparam logic [23:0] PAT = 24'h0000F0;
  logic clk, rst_b, run, sysref, edge_past, step_fine, captured, busy;
  logic [7:0] thr_n, thr_i;
  logic [23:0] phase;
  logic [3:0] sel_o, wstrb;
  sca_pkg::sca_dly_s dly;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int mismatches, tests_run;
  sca_top i_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .SYSREF_I(sysref), .PHASE_SAMPLE_I(phase),
    .CAL_EDGE_PAST_I(edge_past), .DLY_O(dly), .WINDOW_STEP_FINE_O(step_fine),
    .CAPTURE_POSITION_SELECT_O(sel_o), .SYSREF_CAPTURED_O(captured), .ALIGN_CAL_BUSY_O(busy),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  sca_clkgen_model #(.PERIOD(16), .PATTERN(PAT)) i_gen (.clk_i(clk), .run_i(run), .dly_i(dly),
    .thr_norm_i(thr_n), .thr_inv_i(thr_i), .sysref_o(sysref), .phase_sample_o(phase),
    .edge_past_o(edge_past));
  // ==========================================================
  // Bus tasks
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  task automatic results();
    $display("mismatches %0d, comparisons %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("unexpected wait overrun at %0t", $time);
    results();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready is sampled on the falling edge, where it already holds its value for the next rise.
  task automatic wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] resp);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    @(posedge clk);
    awaddr <= ad(idx);
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs && n < 200) begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_hs) timeout();
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] resp);
    int n;
    logic a_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    @(posedge clk);
    araddr <= ad(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs && n < 200) begin
      @(negedge clk);
      a_hs = arvalid && arready;
      r_hs = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge clk);
      if (a_hs) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_hs) timeout();
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, sca_pkg::RESP_OKAY});
  endtask
  // ==========================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    int n;
    logic [3:0] sels [4];
    sels = '{4'h3, 4'h4, 4'h7, 4'h8};
    {rst_b, run, thr_n, thr_i, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(sca_pkg::IDX_MAP_LOW, 32'h0000_0001);
    rdchk(sca_pkg::IDX_MAP_HIGH, 32'h0000_0080);
    rdchk(sca_pkg::IDX_CAL_STAT, 32'h0000_0000);
    run <= 1'b1;
    repeat (100) @(posedge clk);
    rdchk(sca_pkg::IDX_CAL_STAT, 32'h0000_0002);
    rdchk(sca_pkg::IDX_MAP_LOW, 32'h0000_0099);
    rdchk(sca_pkg::IDX_MAP_MID, 32'h0000_0001);
    rdchk(sca_pkg::IDX_MAP_HIGH, 32'h0000_0080);
    wr(sca_pkg::IDX_MAP_LOW, 32'h0000_00FF, r);
    chk({30'h0, r}, {30'h0, sca_pkg::RESP_OKAY});
    rdchk(sca_pkg::IDX_MAP_LOW, 32'h0000_0099);
    rd(8'h3F, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, sca_pkg::RESP_SLVERR});
    for (int k = 0; k < 4; k++) begin
      wr(sca_pkg::IDX_CAP_CTRL, {28'h0, sels[k]}, r);
      repeat (6) @(posedge clk);
      chk({31'h0, captured}, {31'h0, PAT[sels[k]]});
    end
    wr(sca_pkg::IDX_CAP_CTRL, 32'h0000_001F, r);
    rdchk(sca_pkg::IDX_CAP_CTRL, 32'h0000_001F);
    chk({27'h0, step_fine, sel_o}, 32'h0000_001F);
    $display("test window done");
    // Slow ramp, then a fast ramp retargeted from the value reached.
    wr(sca_pkg::IDX_DLY_CTRL, 32'h0002_0008, r);
    repeat (128) @(posedge clk);
    rdchk(sca_pkg::IDX_DLY_APPLIED, 32'h0000_0000);
    repeat (256) @(posedge clk);
    rdchk(sca_pkg::IDX_DLY_APPLIED, 32'h0000_0100);
    wr(sca_pkg::IDX_DLY_CTRL, 32'h0006_0008, r);
    repeat (128) @(posedge clk);
    rdchk(sca_pkg::IDX_DLY_APPLIED, 32'h0000_0100);
    repeat (256) @(posedge clk);
    rdchk(sca_pkg::IDX_DLY_APPLIED, 32'h0000_0500);
    repeat (256) @(posedge clk);
    rdchk(sca_pkg::IDX_DLY_APPLIED, 32'h0000_0800);
    repeat (256) @(posedge clk);
    rdchk(sca_pkg::IDX_DLY_APPLIED, 32'h0000_0800);
    wr(sca_pkg::IDX_DLY_CTRL, 32'h0001_2203, r);
    repeat (3) @(posedge clk);
    chk(32'(dly), 32'h0001_0322);
    rdchk(sca_pkg::IDX_DLY_CTRL, 32'h0001_2203);
    $display("test ramp done");
    wr(sca_pkg::IDX_CAP_CTRL, 32'h0000_0000, r);
    for (int k = 0; k < 2; k++) begin
      thr_n <= k ? 8'h04 : 8'h0A;
      thr_i <= 8'h04;
      wr(sca_pkg::IDX_CAL_CFG, 32'h0000_005A, r);
      rdchk(sca_pkg::IDX_CAL_CFG, 32'h0000_005A);
      wr(sca_pkg::IDX_CAL_EN, 32'h0000_0001, r);
      chk({30'h0, r}, {30'h0, sca_pkg::RESP_OKAY});
      repeat (3) @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      n = 0;
      d = 32'h0;
      while (d[0] !== 1'b1 && n < 200) begin
        repeat (10) @(posedge clk);
        rd(sca_pkg::IDX_CAL_STAT, d, r);
        n++;
      end
      if (d[0] !== 1'b1) timeout();
      rdchk(sca_pkg::IDX_CAL_STAT, k ? 32'h0000_0403 : 32'h0001_0403);
      chk(32'({dly.inv, dly.coarse}), k ? 32'h004 : 32'h104);
      wr(sca_pkg::IDX_CAL_EN, 32'h0000_0000, r);
    end
    repeat (3) @(posedge clk);
    chk(32'(dly), 32'h0001_0322);
    $display("test calibration done");
    results();
  end
endmodule
